// ===== hw/tcts_pkg.sv
// Package for the terminal confidence test sequencer.
// Assumes a single 125 MHz system clock; all counts are in cycles of it.
package tcts_pkg;

	localparam int          LAMP_COUNT       = 8;
	localparam logic [7:0]  LAMPS_ALL_ON     = 8'hff;
	localparam logic [7:0]  LAMPS_RST        = 8'h00;
	localparam int          LAMP_DISPLAY     = 0;
	localparam int          LAMP_MAIN_RAM    = 1;
	localparam int          LAMP_ROM_A       = 2;
	localparam int          LAMP_ROM_B       = 3;
	localparam int          LAMP_SERIAL      = 4;
	localparam int          LAMP_COMM_PROC   = 5;
	localparam int          LAMP_LINK        = 6;
	localparam int          LAMP_COMM_RAM    = 7;
	localparam int          ROM_BLOCK_BYTES  = 2048;
	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          BUZZ_TIME_NS     = 100000;
	localparam int          BUZZ_CYCLES      = BUZZ_TIME_NS / CLK_PERIOD_NS;
	localparam int          RESET_HOLD_NS    = 1000;
	localparam int          RESET_CYCLES     = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  ASTERISK         = 8'h2a;
	localparam logic [2:0]  SUCCESS_LEN      = 3'h5;
	localparam logic [3:0]  TEST_NONE        = 4'h0;
	localparam logic [15:0] FETCH_ADDR_RST   = 16'h0000;

	// Sequencer states; the subsystem test steps stand in indicator order.
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_RESET   = 4'b0001,
		ST_CLEAR   = 4'b0011,
		ST_MAIN    = 4'b0010,
		ST_DISP    = 4'b0110,
		ST_RAM     = 4'b0111,
		ST_ROM     = 4'b0101,
		ST_SERIAL  = 4'b0100,
		ST_CPROC   = 4'b1100,
		ST_LINK    = 4'b1101,
		ST_CRAM    = 4'b1111,
		ST_REPORT  = 4'b1110,
		ST_HALT    = 4'b1010
	} tcts_state_t;

endpackage

// ===== hw/tcts_sequencer.sv
// Terminal confidence test sequencer: starts the test, clears refresh memory, steps through
// subsystem tests in order, drives lamps, buzzer and screen, and handles failures.
// Assumes the processors report each subsystem verdict as a one-cycle pass or fail pulse
// on the same clock; start requests from keyboard and comm link come from pins.
`timescale 1ns/1ps
`default_nettype none

module tcts_sequencer
	import tcts_pkg::*;
#(
	parameter int REFRESH_DEPTH = 2048,
	parameter int ROM_BLOCKS    = 16,
	parameter int BUZZ_LEN      = BUZZ_CYCLES
) (
	// Clock and reset.
	input  wire logic                             sys_clk_in,
	input  wire logic                             rst_in,
	// Start requests from pins.
	input  wire logic                             kbd_ctrl_req_in,
	input  wire logic                             comm_esc_req_in,
	// Subsystem verdicts, one-cycle pulses.
	input  wire logic                             test_pass_in,
	input  wire logic                             test_fail_in,
	input  wire logic                             rom_block_bad_in,
	input  wire logic [$clog2(ROM_BLOCKS)-1:0]    rom_block_idx_in,
	input  wire logic                             diag_done_in,
	// Processor control.
	output logic                                  proc_reset_out,
	output logic [15:0]                           main_fetch_addr_out,
	output logic [15:0]                           comm_fetch_addr_out,
	output logic                                  comm_load_out,
	output logic [3:0]                            test_sel_out,
	output logic                                  diag_run_out,
	// Indicators and display.
	output logic [LAMP_COUNT-1:0]                 lamps_out,
	output logic                                  buzzer_out,
	output logic                                  refresh_wr_out,
	output logic [$clog2(REFRESH_DEPTH)-1:0]      refresh_addr_out,
	output logic [7:0]                            refresh_data_out,
	output logic                                  screen_mirror_out,
	output logic [LAMP_COUNT-1:0]                 screen_lamps_out,
	output logic [ROM_BLOCKS-1:0]                 rom_bad_map_out,
	// Link status.
	output logic                                  online_out,
	output logic                                  result_tx_out,
	output logic                                  test_active_out
);

	localparam int AW = $clog2(REFRESH_DEPTH);
	localparam int BW = $clog2(BUZZ_LEN + 1);
	localparam int RW = $clog2(RESET_CYCLES + 1);

	// Pin synchronisers: three stages, change counts when stages two and three agree.
	logic [2:0] kbd_sync_ff;
	logic [2:0] esc_sync_ff;
	logic       kbd_lvl_ff;
	logic       esc_lvl_ff;
	logic       nxt_kbd_lvl;
	logic       nxt_esc_lvl;

	always_comb begin
		nxt_kbd_lvl = kbd_lvl_ff;
		nxt_esc_lvl = esc_lvl_ff;
		if (kbd_sync_ff[1] == kbd_sync_ff[2]) begin
			nxt_kbd_lvl = kbd_sync_ff[2];
		end
		if (esc_sync_ff[1] == esc_sync_ff[2]) begin
			nxt_esc_lvl = esc_sync_ff[2];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			kbd_sync_ff <= 3'h0;
			esc_sync_ff <= 3'h0;
			kbd_lvl_ff  <= 1'b0;
			esc_lvl_ff  <= 1'b0;
		end else begin
			kbd_sync_ff <= {kbd_sync_ff[1:0], kbd_ctrl_req_in};
			esc_sync_ff <= {esc_sync_ff[1:0], comm_esc_req_in};
			kbd_lvl_ff  <= nxt_kbd_lvl;
			esc_lvl_ff  <= nxt_esc_lvl;
		end
	end

	wire logic kbd_start = nxt_kbd_lvl & ~kbd_lvl_ff;
	wire logic esc_start = nxt_esc_lvl & ~esc_lvl_ff;

	// Sequencer state.
	tcts_state_t                   state_ff, nxt_state;
	logic [AW-1:0]                 clr_addr_ff, nxt_clr_addr;
	logic [RW-1:0]                 rst_cnt_ff, nxt_rst_cnt;
	logic [BW-1:0]                 buzz_cnt_ff, nxt_buzz_cnt;
	logic [2:0]                    msg_cnt_ff, nxt_msg_cnt;
	logic [LAMP_COUNT-1:0]         lamps_ff, nxt_lamps;
	logic [ROM_BLOCKS-1:0]         rom_bad_ff, nxt_rom_bad;
	logic                          failed_ff, nxt_failed;
	logic                          esc_src_ff, nxt_esc_src;
	logic                          online_ff, nxt_online;
	logic                          tx_ff, nxt_tx;
	logic                          diag_ff, nxt_diag;
	logic                          load_ff, nxt_load;
	logic                          wr_ff, nxt_wr;
	logic [7:0]                    data_ff, nxt_data;
	logic                          mirror_ff, nxt_mirror;
	logic                          fatal_ff, nxt_fatal;

	// Next step in indicator order.
	function automatic tcts_state_t next_test(input tcts_state_t s);
		unique case (s)
			ST_MAIN:   next_test = ST_DISP;
			ST_DISP:   next_test = ST_RAM;
			ST_RAM:    next_test = ST_ROM;
			ST_ROM:    next_test = ST_SERIAL;
			ST_SERIAL: next_test = ST_CPROC;
			ST_CPROC:  next_test = ST_LINK;
			ST_LINK:   next_test = ST_CRAM;
			default:   next_test = ST_REPORT;
		endcase
	endfunction

	// Main processor and ROM failures impair the test itself.
	wire logic fatal_step = (state_ff == ST_MAIN) || (state_ff == ST_ROM);
	wire logic in_test    = (state_ff == ST_MAIN) || (state_ff == ST_DISP) || (state_ff == ST_RAM) ||
	                        (state_ff == ST_ROM) || (state_ff == ST_SERIAL) || (state_ff == ST_CPROC) ||
	                        (state_ff == ST_LINK) || (state_ff == ST_CRAM);
	wire logic start_req  = kbd_start | esc_start;

	always_comb begin
		nxt_state    = state_ff;
		nxt_clr_addr = clr_addr_ff;
		nxt_rst_cnt  = rst_cnt_ff;
		nxt_buzz_cnt = (buzz_cnt_ff != '0) ? buzz_cnt_ff - 1'b1 : buzz_cnt_ff;
		nxt_msg_cnt  = msg_cnt_ff;
		nxt_lamps    = lamps_ff;
		nxt_rom_bad  = rom_bad_ff;
		nxt_failed   = failed_ff;
		nxt_esc_src  = esc_src_ff;
		nxt_online   = online_ff;
		nxt_tx       = 1'b0;
		nxt_diag     = diag_ff;
		nxt_load     = 1'b0;
		nxt_wr       = 1'b0;
		nxt_data     = data_ff;
		nxt_mirror   = mirror_ff;
		nxt_fatal    = fatal_ff;
		if (start_req && (state_ff == ST_IDLE || state_ff == ST_HALT)) begin
			nxt_state   = ST_RESET;
			nxt_rst_cnt = RW'(RESET_CYCLES);
			nxt_esc_src = esc_start;
			nxt_lamps   = LAMPS_ALL_ON;
		end else begin
			unique case (state_ff)
				ST_IDLE, ST_HALT: begin
				end
				ST_RESET: begin
					if (rst_cnt_ff == '0) begin
						nxt_state    = ST_CLEAR;
						nxt_clr_addr = '0;
						nxt_failed   = 1'b0;
						nxt_fatal    = 1'b0;
						nxt_mirror   = 1'b0;
						nxt_rom_bad  = '0;
						nxt_diag     = 1'b0;
					end else begin
						nxt_rst_cnt = rst_cnt_ff - 1'b1;
					end
				end
				ST_CLEAR: begin
					nxt_wr       = 1'b1;
					nxt_data     = 8'h00;
					nxt_clr_addr = clr_addr_ff + 1'b1;
					if (clr_addr_ff == AW'(REFRESH_DEPTH - 1)) begin
						nxt_state = ST_MAIN;
					end
				end
				ST_REPORT: begin
					if (failed_ff) begin
						nxt_mirror = 1'b1;
						nxt_online = ~esc_src_ff & online_ff;
						nxt_state  = ST_IDLE;
					end else if (msg_cnt_ff != SUCCESS_LEN) begin
						nxt_wr      = 1'b1;
						nxt_data    = ASTERISK;
						nxt_clr_addr = AW'(msg_cnt_ff);
						nxt_msg_cnt = msg_cnt_ff + 1'b1;
					end else begin
						nxt_tx    = 1'b1;
						nxt_state = ST_IDLE;
					end
				end
				default: begin
					if (in_test && diag_ff) begin
						if (diag_done_in) begin
							nxt_diag = 1'b0;
							if (fatal_ff) begin
								nxt_mirror = 1'b1;
								nxt_online = ~esc_src_ff & online_ff;
								nxt_state  = ST_HALT;
							end else begin
								nxt_state = next_test(state_ff);
							end
						end
					end else if (in_test) begin
						if (state_ff == ST_ROM && rom_block_bad_in) begin
							nxt_rom_bad[rom_block_idx_in] = 1'b1;
						end
						if (test_pass_in && !(state_ff == ST_ROM && (rom_bad_ff != '0))) begin
							unique case (state_ff)
								ST_MAIN: begin
									nxt_lamps    = LAMPS_ALL_ON;
									nxt_buzz_cnt = BW'(BUZZ_LEN);
								end
								ST_DISP: nxt_lamps[LAMP_DISPLAY] = 1'b0;
								ST_RAM:  nxt_lamps[LAMP_MAIN_RAM] = 1'b0;
								ST_ROM: begin
									nxt_lamps[LAMP_ROM_A] = 1'b0;
									nxt_lamps[LAMP_ROM_B] = 1'b0;
								end
								ST_SERIAL: nxt_lamps[LAMP_SERIAL] = 1'b0;
								ST_CPROC: begin
									nxt_lamps[LAMP_COMM_PROC] = 1'b0;
									nxt_load = 1'b1;
								end
								ST_LINK: nxt_lamps[LAMP_LINK] = 1'b0;
								default: nxt_lamps[LAMP_COMM_RAM] = 1'b0;
							endcase
							nxt_state = next_test(state_ff);
						end else if (test_fail_in || (test_pass_in && state_ff == ST_ROM)) begin
							nxt_failed = 1'b1;
							nxt_diag   = 1'b1;
							nxt_fatal  = fatal_step;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff    <= ST_RESET;
			clr_addr_ff <= '0;
			rst_cnt_ff  <= RW'(RESET_CYCLES);
			buzz_cnt_ff <= '0;
			msg_cnt_ff  <= 3'h0;
			lamps_ff    <= LAMPS_RST;
			rom_bad_ff  <= '0;
			failed_ff   <= 1'b0;
			esc_src_ff  <= 1'b0;
			online_ff   <= 1'b1;
			tx_ff       <= 1'b0;
			diag_ff     <= 1'b0;
			load_ff     <= 1'b0;
			wr_ff       <= 1'b0;
			data_ff     <= 8'h00;
			mirror_ff   <= 1'b0;
			fatal_ff    <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			clr_addr_ff <= nxt_clr_addr;
			rst_cnt_ff  <= nxt_rst_cnt;
			buzz_cnt_ff <= nxt_buzz_cnt;
			msg_cnt_ff  <= (nxt_state == ST_CLEAR) ? 3'h0 : nxt_msg_cnt;
			lamps_ff    <= nxt_lamps;
			rom_bad_ff  <= nxt_rom_bad;
			failed_ff   <= nxt_failed;
			esc_src_ff  <= nxt_esc_src;
			online_ff   <= (nxt_state == ST_RESET && state_ff != ST_RESET) ? 1'b1 : nxt_online;
			tx_ff       <= nxt_tx;
			diag_ff     <= nxt_diag;
			load_ff     <= nxt_load;
			wr_ff       <= nxt_wr;
			data_ff     <= nxt_data;
			mirror_ff   <= nxt_mirror;
			fatal_ff    <= nxt_fatal;
		end
	end

	// Registered outputs.
	logic                  proc_rst_ff;
	logic [3:0]            sel_ff;
	logic [AW-1:0]         addr_out_ff;
	logic                  active_ff;
	logic                  buzz_ff;
	logic [LAMP_COUNT-1:0] screen_ff;

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			proc_rst_ff <= 1'b1;
			sel_ff      <= TEST_NONE;
			addr_out_ff <= '0;
			active_ff   <= 1'b0;
			buzz_ff     <= 1'b0;
			screen_ff   <= '0;
		end else begin
			proc_rst_ff <= (nxt_state == ST_RESET);
			sel_ff      <= nxt_state;
			addr_out_ff <= (state_ff == ST_CLEAR) ? clr_addr_ff : nxt_clr_addr;
			active_ff   <= (nxt_state != ST_IDLE) && (nxt_state != ST_HALT);
			buzz_ff     <= (nxt_buzz_cnt != '0);
			screen_ff   <= nxt_mirror ? nxt_lamps : '0;
		end
	end

	assign proc_reset_out      = proc_rst_ff;
	assign main_fetch_addr_out = FETCH_ADDR_RST;
	assign comm_fetch_addr_out = FETCH_ADDR_RST;
	assign comm_load_out       = load_ff;
	assign test_sel_out        = sel_ff;
	assign diag_run_out        = diag_ff;
	assign lamps_out           = lamps_ff;
	assign buzzer_out          = buzz_ff;
	assign refresh_wr_out      = wr_ff;
	assign refresh_addr_out    = addr_out_ff;
	assign refresh_data_out    = data_ff;
	assign screen_mirror_out   = mirror_ff;
	assign screen_lamps_out    = screen_ff;
	assign rom_bad_map_out     = rom_bad_ff;
	assign online_out          = online_ff;
	assign result_tx_out       = tx_ff;
	assign test_active_out     = active_ff;

endmodule

`default_nettype wire

// ===== test/tcts_sequencer_monitor.sv
// Checker for the confidence test sequencer.
// Assumes it is bound to tcts_sequencer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tcts_sequencer_monitor
	import tcts_pkg::*;
#(
	parameter int BUZZ_LEN = BUZZ_CYCLES
) (
	// Clock, reset and verdicts.
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	input wire logic       test_pass_in,
	input wire logic       test_fail_in,
	// Observed outputs.
	input wire logic       proc_reset_out,
	input wire logic [3:0] test_sel_out,
	input wire logic       diag_run_out,
	input wire logic [7:0] lamps_out,
	input wire logic       buzzer_out,
	input wire logic       refresh_wr_out,
	input wire logic [7:0] refresh_data_out,
	input wire logic       screen_mirror_out,
	input wire logic [7:0] screen_lamps_out,
	input wire logic       result_tx_out
);
	logic [15:0] rst_cnt_ff;
	logic [15:0] buzz_cnt_ff;
	// Counts how long processor reset and the buzzer have been held.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_cnt_ff  <= 16'h0000;
			buzz_cnt_ff <= 16'h0000;
		end else begin
			rst_cnt_ff  <= proc_reset_out ? rst_cnt_ff + 16'h0001 : 16'h0000;
			buzz_cnt_ff <= buzzer_out ? buzz_cnt_ff + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	reset_hold_a: assert property ($fell(proc_reset_out) |-> rst_cnt_ff >= RESET_CYCLES)
		else $error("processor reset released too early");
	buzz_len_a: assert property ($fell(buzzer_out) |-> buzz_cnt_ff == BUZZ_LEN)
		else $error("buzzer length wrong");
	main_lamps_a: assert property (test_sel_out == ST_MAIN && test_pass_in |-> ##[1:2] (lamps_out == LAMPS_ALL_ON && buzzer_out))
		else $error("main pass did not light lamps and buzzer");
	disp_lamp_a: assert property (test_sel_out == ST_DISP && test_pass_in |=> !lamps_out[LAMP_DISPLAY])
		else $error("display lamp still lit");
	rom_lamps_a: assert property (test_sel_out == ST_ROM && test_pass_in |=> ((lamps_out[LAMP_ROM_B:LAMP_ROM_A] == 2'b00) != diag_run_out))
		else $error("rom lamps still lit");
	lamp_hold_a: assert property (test_fail_in |=> $stable(lamps_out))
		else $error("lamps changed on a failure");
	star_msg_a: assert property (refresh_wr_out && test_sel_out == ST_REPORT |-> refresh_data_out == ASTERISK)
		else $error("success message is not asterisks");
	diag_start_a: assert property (test_fail_in |-> ##[1:2] diag_run_out)
		else $error("diagnostic did not start");
	mirror_copy_a: assert property (screen_lamps_out == (screen_mirror_out ? lamps_out : 8'h00))
		else $error("screen does not mirror lamps");
	tx_success_a: assert property (result_tx_out |-> !screen_mirror_out)
		else $error("results sent after a failure");
	cover property (test_sel_out == ST_REPORT && refresh_wr_out);
	cover property (test_sel_out == ST_HALT);
	cover property ($fell(buzzer_out));
endmodule
`default_nettype wire

// ===== test/tcts_proc_model.sv
// Model of the main, display and comm processors answering each subsystem test.
// Assumes the sequencer's state code tells which test runs; the bench picks the failing one.
`timescale 1ns/1ps
`default_nettype none
module tcts_proc_model
	import tcts_pkg::*;
(
	// Clock and reset.
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	// Sequencer state and scenario control.
	input  wire logic [3:0] test_sel_in,
	input  wire logic       diag_run_in,
	input  wire logic [3:0] fail_sel_in,
	input  wire logic [3:0] delay_in,
	// Verdicts towards the sequencer.
	output logic            test_pass_out,
	output logic            test_fail_out,
	output logic            rom_block_bad_out,
	output logic [3:0]      rom_block_idx_out,
	output logic            diag_done_out
);
	logic [3:0] seen_ff;
	logic [3:0] wait_ff;
	logic [3:0] dwait_ff;
	logic       act;
	assign act = test_sel_in inside {ST_MAIN, ST_DISP, ST_RAM, ST_ROM, ST_SERIAL, ST_CPROC, ST_LINK, ST_CRAM};
	// One verdict per test after delay_in cycles; the block index wanders when unused.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{seen_ff, wait_ff, dwait_ff, rom_block_idx_out} <= '0;
			{test_pass_out, test_fail_out, rom_block_bad_out, diag_done_out} <= '0;
		end else begin
			{test_pass_out, test_fail_out, rom_block_bad_out, diag_done_out} <= '0;
			rom_block_idx_out <= wait_ff;
			wait_ff <= (act && test_sel_in != seen_ff) ? wait_ff + 4'h1 : 4'h0;
			if (!act)
				seen_ff <= ST_IDLE;
			if (act && test_sel_in != seen_ff && wait_ff == delay_in) begin
				seen_ff <= test_sel_in;
				// A failing ROM step with an odd delay reports pass after a bad block.
				test_pass_out <= test_sel_in != fail_sel_in || (test_sel_in == ST_ROM && delay_in[0]);
				test_fail_out <= test_sel_in == fail_sel_in && !(test_sel_in == ST_ROM && delay_in[0]);
			end
			if (act && test_sel_in == fail_sel_in && test_sel_in == ST_ROM && wait_ff == 4'h1)
				rom_block_bad_out <= 1'b1;
			dwait_ff <= diag_run_in ? dwait_ff + 4'h1 : 4'h0;
			diag_done_out <= diag_run_in && dwait_ff == delay_in;
		end
	end
endmodule
`default_nettype wire

// ===== test/tcts_sequencer_tb.sv
// Self-checking bench for the confidence test sequencer with a processor model.
// Assumes the package, the sequencer, the model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tcts_sequencer_tb;
	import tcts_pkg::*;
	localparam int DEPTH = 16;
	localparam int BUZZ  = 4;
	localparam logic [3:0] STEPS [8] = '{ST_MAIN, ST_DISP, ST_RAM, ST_ROM, ST_SERIAL, ST_CPROC, ST_LINK, ST_CRAM};
	localparam logic [7:0] MASKS [8] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h10, 8'h20, 8'h40, 8'h80};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        kbd = 1'b0;
	logic        esc = 1'b0;
	logic [3:0]  fail_sel = 4'h0;
	logic [3:0]  dly = 4'h3;
	logic        pass, fail, bad, done, prst, load, diag, buzz, rwr, mirror, online, tx, active, diag_q;
	logic [3:0]  idx, sel, raddr;
	logic [7:0]  lamps, rdata, slamps;
	logic [15:0] maddr, caddr, badmap;
	logic [31:0] seed = 32'h343a;
	int          fail_count = 0;
	int          tests_run = 0;
	int          n_clear, n_star, n_tx, n_load, n_buzz, n_rst, n_diag;
	always #4 clk = ~clk;
	tcts_sequencer #(.REFRESH_DEPTH(DEPTH), .ROM_BLOCKS(16), .BUZZ_LEN(BUZZ)) i_tcts_sequencer (
		.sys_clk_in(clk), .rst_in(rst), .kbd_ctrl_req_in(kbd), .comm_esc_req_in(esc), .test_pass_in(pass),
		.test_fail_in(fail), .rom_block_bad_in(bad), .rom_block_idx_in(idx), .diag_done_in(done),
		.proc_reset_out(prst), .main_fetch_addr_out(maddr), .comm_fetch_addr_out(caddr), .comm_load_out(load),
		.test_sel_out(sel), .diag_run_out(diag), .lamps_out(lamps), .buzzer_out(buzz), .refresh_wr_out(rwr),
		.refresh_addr_out(raddr), .refresh_data_out(rdata), .screen_mirror_out(mirror),
		.screen_lamps_out(slamps), .rom_bad_map_out(badmap), .online_out(online), .result_tx_out(tx),
		.test_active_out(active));
	tcts_proc_model i_tcts_proc_model (
		.sys_clk_in(clk), .rst_in(rst), .test_sel_in(sel), .diag_run_in(diag), .fail_sel_in(fail_sel),
		.delay_in(dly), .test_pass_out(pass), .test_fail_out(fail), .rom_block_bad_out(bad),
		.rom_block_idx_out(idx), .diag_done_out(done));
	// Tallies what the sequencer does during one run.
	always @(posedge clk) begin
		diag_q <= diag;
		n_clear += int'(rwr === 1'b1 && rdata === 8'h00 && raddr === 4'(n_clear));
		n_star += int'(rwr === 1'b1 && rdata === ASTERISK && raddr === 4'(n_star));
		n_tx += int'(tx === 1'b1);
		n_load += int'(load === 1'b1);
		n_buzz += int'(buzz === 1'b1);
		n_rst += int'(prst === 1'b1);
		n_diag += int'(diag === 1'b1 && diag_q !== 1'b1);
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input bit ok);
		tests_run++;
		if (!ok) begin
			fail_count++;
			$display("BAD %0t mismatch in run with failing step %0d", $time, fail_sel);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One test run: f is the failing step (8 for none), src 0 power, 1 keyboard, 2 escape.
	task automatic run(input int f, input int src, input logic [3:0] d);
		int n;
		logic [7:0] exp;
		exp = 8'hff;
		for (int i = 1; i < 8; i++)
			if (i != f && !(f == 3 && i > 3))
				exp = exp & ~MASKS[i];
		@(negedge clk);
		{n_clear, n_star, n_tx, n_load, n_buzz, n_rst, n_diag} = '0;
		@(posedge clk);
		fail_sel <= (f < 8) ? STEPS[f] : ST_IDLE;
		dly <= d;
		if (src == 0) begin
			rst <= 1'b1;
			@(negedge clk);
			{n_clear, n_star, n_tx, n_load, n_buzz, n_rst, n_diag} = '0;
			repeat (3) @(posedge clk);
			chk(prst === 1'b1 && lamps === LAMPS_RST && online === 1'b1);
			rst <= 1'b0;
		end else if (src == 1)
			kbd <= 1'b1;
		else
			esc <= 1'b1;
		repeat (8) @(posedge clk);
		{kbd, esc} <= 2'b00;
		n = 0;
		while (n < 3000 && sel !== ST_IDLE && sel !== ST_HALT) begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		chk(n < 3000 && n_clear == DEPTH && n_rst >= RESET_CYCLES);
		chk(n_buzz == ((f == 0) ? 0 : BUZZ));
		if (f != 0)
			chk((lamps | ((f == 3) ? 8'h04 : 8'h00)) === exp);
		chk(mirror === (f < 8) && slamps === ((f < 8) ? lamps : 8'h00));
		chk(n_star == ((f == 8) ? 5 : 0) && n_tx == int'(f == 8));
		chk((sel === ST_HALT) == (f == 0 || f == 3) && n_diag == int'(f < 8) && active === 1'b0);
		chk(n_load == int'(f != 0 && f != 3 && f != 5));
		if (f == 3)
			chk(badmap === 16'h0002);
		chk(online === !(src == 2 && f < 8));
		chk(maddr === FETCH_ADDR_RST && caddr === FETCH_ADDR_RST);
	endtask
	initial begin
		for (int f = 0; f < 9; f++)
			run(f, f % 3, 4'h2 + 4'(f % 4));
		for (int k = 0; k < 12; k++) begin
			seed = xs(seed);
			run(int'(seed % 9), int'(seed[9:8] % 3), 4'h2 + 4'(seed[14:12]));
		end
		kbd <= 1'b1;
		repeat (140) @(posedge clk);
		run(8, 0, 4'h3);
		wrap_up();
	end
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule
bind tcts_sequencer tcts_sequencer_monitor #(.BUZZ_LEN(BUZZ_LEN)) i_tcts_sequencer_monitor (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .test_pass_in(test_pass_in), .test_fail_in(test_fail_in),
	.proc_reset_out(proc_reset_out), .test_sel_out(test_sel_out), .diag_run_out(diag_run_out),
	.lamps_out(lamps_out), .buzzer_out(buzzer_out), .refresh_wr_out(refresh_wr_out),
	.refresh_data_out(refresh_data_out), .screen_mirror_out(screen_mirror_out),
	.screen_lamps_out(screen_lamps_out), .result_tx_out(result_tx_out));
`default_nettype wire
